// ### hdl/bus_pkg.sv
// Shared constants, register layout and carrier types of the bus matrix
package bus_pkg;
  // ==========================================================
  // Sizes
  localparam int MASTERS = 5;
  localparam int SLAVES  = 10;
  localparam int MID_W   = 3;
  localparam int SID_W   = 4;
  localparam int PRIO_W  = 2;
  localparam int SLOT_W  = 8;
  localparam int ADDR_W  = 9;

  // ==========================================================
  // Encodings
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] KIND_NONE  = 2'h0;
  localparam logic [1:0] KIND_LAST  = 2'h1;
  localparam logic [1:0] KIND_FIXED = 2'h2;
  localparam logic       ARB_RR     = 1'h0;
  localparam logic       ARB_PRIO   = 1'h1;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CFG_BASE  = 9'h040;
  localparam logic [ADDR_W-1:0] PRIO_BASE = 9'h080;
  localparam logic [ADDR_W-1:0] STAT_BASE = 9'h0c0;
  localparam logic [ADDR_W-1:0] REMAP_OFF = 9'h100;

  // ==========================================================
  // Field positions
  localparam int SLOT_LSB  = 0;
  localparam int KIND_LSB  = 16;
  localparam int FIXED_LSB = 18;
  localparam int ARBITRATION_TYPE_SEL_BIT  = 24;
  localparam int VLD_BIT   = 4;

  // ==========================================================
  // Address decode
  localparam int              REGION_LSB  = 28;
  localparam logic [SID_W-1:0] REMAP_SLAVE = 4'h1;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [1:0]  trans;
    logic [31:0] addr;
    logic        write;
    logic        last;
    logic [31:0] wdata;
  } mreq_t;

  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
  } mrsp_t;

  typedef struct packed {
    logic             sel;
    logic [1:0]       trans;
    logic [31:0]      addr;
    logic             write;
    logic [31:0]      wdata;
    logic [MID_W-1:0] owner;
  } sreq_t;

  typedef mrsp_t srsp_t;

  typedef struct packed {
    logic [1:0]        kind;
    logic [SID_W-1:0]  fixed;
    logic              arbitration_type_sel;
    logic [SLOT_W-1:0] slot;
  } scfg_t;

  // ==========================================================
  // Reset values
  localparam scfg_t            CFG_RST  = '{kind: KIND_LAST, fixed: 4'h0,
                                            arbitration_type_sel: ARB_RR, slot: 8'h10};
  localparam logic [MID_W-1:0] RR_START = 3'h4;
endpackage

// ### hdl/arb_pick.sv
// Per-slave winner selection: round-robin or fixed priority
`timescale 1ns/1ps
module arb_pick (
  input  wire logic [bus_pkg::MASTERS-1:0]                    req_in,
  input  wire logic [bus_pkg::MASTERS-1:0][bus_pkg::PRIO_W-1:0] prio_in,
  input  wire logic                                           type_in,
  input  wire logic [bus_pkg::MID_W-1:0]                      last_in,
  output logic      [bus_pkg::MID_W-1:0]                      pick_out,
  output logic                                                any_out
);
  int          idx;
  logic [bus_pkg::PRIO_W-1:0] best;

  always_comb begin
    idx      = 0;
    best     = '0;
    pick_out = '0;
    any_out  = |req_in;
    if (type_in == bus_pkg::ARB_RR) begin
      // Nearest after the previous winner wins; walk from far to near
      for (int k = bus_pkg::MASTERS; k >= 1; k--) begin
        idx = int'(last_in) + k;
        if (idx >= bus_pkg::MASTERS) begin
          idx = idx - bus_pkg::MASTERS;
        end
        if (req_in[idx]) begin
          pick_out = idx[bus_pkg::MID_W-1:0];
        end
      end
    end else begin
      // Ties fall to the higher index through >=
      for (int m = 0; m < bus_pkg::MASTERS; m++) begin
        if (req_in[m] && (!any_out || prio_in[m] >= best || pick_out == '0)) begin
          if (prio_in[m] >= best || !req_in[pick_out]) begin
            best     = prio_in[m];
            pick_out = m[bus_pkg::MID_W-1:0];
          end
        end
      end
    end
  end
endmodule

// ### hdl/bus_matrix.sv
// Multi-layer bus matrix: decoders, per-slave arbiters and config registers
`timescale 1ns/1ps
module bus_matrix (
  input  wire logic                                   clock_in,
  input  wire logic                                   rst_in,
  input  wire bus_pkg::mreq_t [bus_pkg::MASTERS-1:0]  master_req_in,
  output bus_pkg::mrsp_t      [bus_pkg::MASTERS-1:0]  master_rsp_out,
  output bus_pkg::sreq_t      [bus_pkg::SLAVES-1:0]   slave_req_out,
  input  wire bus_pkg::srsp_t [bus_pkg::SLAVES-1:0]   slave_rsp_in,
  input  wire logic [bus_pkg::ADDR_W-1:0]             reg_addr_in,
  input  wire logic [31:0]                            reg_wdata_in,
  input  wire logic                                   reg_write_in,
  input  wire logic                                   reg_read_in,
  output logic      [31:0]                            reg_rdata_out
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [bus_pkg::SLAVES-1:0][bus_pkg::MID_W-1:0]  owner;
    logic [bus_pkg::SLAVES-1:0]                      vld;
    logic [bus_pkg::SLAVES-1:0][bus_pkg::MID_W-1:0]  rr_last;
    logic [bus_pkg::SLAVES-1:0][bus_pkg::SLOT_W-1:0] slot;
    bus_pkg::scfg_t [bus_pkg::SLAVES-1:0]            cfg;
    logic [bus_pkg::SLAVES-1:0][bus_pkg::MASTERS-1:0][bus_pkg::PRIO_W-1:0] prio;
    logic [bus_pkg::MASTERS-1:0]                     remap;
    logic [31:0]                                     rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [bus_pkg::MASTERS-1:0][bus_pkg::SID_W-1:0] tgt;
  logic [bus_pkg::MASTERS-1:0]                     tgt_ok;
  logic [bus_pkg::SLAVES-1:0][bus_pkg::MASTERS-1:0] req;
  logic [bus_pkg::SLAVES-1:0][bus_pkg::MID_W-1:0]  pick;
  logic [bus_pkg::SLAVES-1:0]                      any;

  // ==========================================================
  // Per-master decoders
  always_comb begin
    for (int m = 0; m < bus_pkg::MASTERS; m++) begin
      tgt[m] = master_req_in[m].addr[bus_pkg::REGION_LSB +: bus_pkg::SID_W];
      if (st_q.remap[m] && tgt[m] == '0) begin
        tgt[m] = bus_pkg::REMAP_SLAVE;
      end
      tgt_ok[m] = (master_req_in[m].trans != bus_pkg::TRANS_IDLE) &&
                  (tgt[m] < bus_pkg::SID_W'(bus_pkg::SLAVES));
    end
    for (int s = 0; s < bus_pkg::SLAVES; s++) begin
      for (int m = 0; m < bus_pkg::MASTERS; m++) begin
        req[s][m] = tgt_ok[m] && (tgt[m] == s[bus_pkg::SID_W-1:0]);
      end
    end
  end

  // ==========================================================
  // One arbiter per slave
  for (genvar g = 0; g < bus_pkg::SLAVES; g++) begin : g_arb
    arb_pick u_arb (
      .req_in   (req[g]),
      .prio_in  (st_q.prio[g]),
      .type_in  (st_q.cfg[g].arbitration_type_sel),
      .last_in  (st_q.rr_last[g]),
      .pick_out (pick[g]),
      .any_out  (any[g])
    );
  end

  // ==========================================================
  // Data paths
  always_comb begin
    logic [bus_pkg::MID_W-1:0] o;
    logic [bus_pkg::SID_W-1:0] s;
    o = '0;
    s = '0;
    for (int k = 0; k < bus_pkg::SLAVES; k++) begin
      o = st_q.owner[k];
      slave_req_out[k] = '0;
      if (st_q.vld[k] && o < bus_pkg::MID_W'(bus_pkg::MASTERS)) begin
        // Only the owner reaches the slave; others never share it
        slave_req_out[k].sel   = req[k][o];
        slave_req_out[k].trans = master_req_in[o].trans;
        slave_req_out[k].addr  = master_req_in[o].addr;
        slave_req_out[k].write = master_req_in[o].write;
        slave_req_out[k].wdata = master_req_in[o].wdata;
        slave_req_out[k].owner = o;
      end
    end
    for (int m = 0; m < bus_pkg::MASTERS; m++) begin
      s = tgt[m];
      master_rsp_out[m].ready = 1'b1;
      master_rsp_out[m].rdata = '0;
      if (tgt_ok[m]) begin
        // Owner passes the same cycle, anyone else stalls for the grant
        master_rsp_out[m].ready = st_q.vld[s] && st_q.owner[s] == m[bus_pkg::MID_W-1:0]
                                  && slave_rsp_in[s].ready;
        master_rsp_out[m].rdata = slave_rsp_in[s].rdata;
      end
    end
  end

  // ==========================================================
  // Grant, default owner and registers
  always_comb begin
    logic [bus_pkg::MID_W-1:0] o;
    logic                      cur;
    logic                      arb_ok;
    logic [3:0]                idx;
    logic                      hit;
    o      = '0;
    cur    = 1'b0;
    arb_ok = 1'b0;
    idx    = reg_addr_in[5:2];
    hit    = (reg_addr_in[1:0] == 2'h0) && (idx < 4'(bus_pkg::SLAVES));
    st_d   = st_q;
    st_d.rdata = '0;

    for (int s = 0; s < bus_pkg::SLAVES; s++) begin
      o   = st_q.owner[s];
      cur = st_q.vld[s] && o < bus_pkg::MID_W'(bus_pkg::MASTERS) && req[s][o];
      if (cur && slave_rsp_in[s].ready && st_q.slot[s] != '0) begin
        st_d.slot[s] = st_q.slot[s] - 8'h01;
      end
      // Switch only while the slave is ready: on a completed beat at a legal point, or when the owner is not requesting
      arb_ok = slave_rsp_in[s].ready &&
               (!cur || master_req_in[o].last || st_q.slot[s] == '0);
      if (arb_ok) begin
        if (any[s]) begin
          if (!cur || pick[s] != o) begin
            st_d.slot[s] = st_q.cfg[s].slot;
          end
          st_d.owner[s]   = pick[s];
          st_d.vld[s]     = 1'b1;
          st_d.rr_last[s] = pick[s];
        end else begin
          case (st_q.cfg[s].kind)
            bus_pkg::KIND_LAST: begin
              st_d.owner[s] = o;
            end
            bus_pkg::KIND_FIXED: begin
              st_d.owner[s] = st_q.cfg[s].fixed[bus_pkg::MID_W-1:0];
              st_d.vld[s]   = st_q.cfg[s].fixed < 4'(bus_pkg::MASTERS);
            end
            default: begin
              st_d.vld[s] = 1'b0;
            end
          endcase
        end
      end
    end

    // Register writes
    if (reg_write_in && hit) begin
      if (reg_addr_in[8:6] == bus_pkg::CFG_BASE[8:6]) begin
        st_d.cfg[idx].slot  = reg_wdata_in[bus_pkg::SLOT_LSB +: bus_pkg::SLOT_W];
        st_d.cfg[idx].kind  = reg_wdata_in[bus_pkg::KIND_LSB +: 2];
        st_d.cfg[idx].fixed = reg_wdata_in[bus_pkg::FIXED_LSB +: bus_pkg::SID_W];
        st_d.cfg[idx].arbitration_type_sel  = reg_wdata_in[bus_pkg::ARBITRATION_TYPE_SEL_BIT];
      end else if (reg_addr_in[8:6] == bus_pkg::PRIO_BASE[8:6]) begin
        for (int m = 0; m < bus_pkg::MASTERS; m++) begin
          st_d.prio[idx][m] = reg_wdata_in[4 * m +: bus_pkg::PRIO_W];
        end
      end
    end
    if (reg_write_in && reg_addr_in == bus_pkg::REMAP_OFF) begin
      st_d.remap = reg_wdata_in[bus_pkg::MASTERS-1:0];
    end

    // Register reads, answered in the next cycle only
    if (reg_read_in && hit) begin
      if (reg_addr_in[8:6] == bus_pkg::CFG_BASE[8:6]) begin
        st_d.rdata[bus_pkg::SLOT_LSB +: bus_pkg::SLOT_W]  = st_q.cfg[idx].slot;
        st_d.rdata[bus_pkg::KIND_LSB +: 2]                = st_q.cfg[idx].kind;
        st_d.rdata[bus_pkg::FIXED_LSB +: bus_pkg::SID_W]  = st_q.cfg[idx].fixed;
        st_d.rdata[bus_pkg::ARBITRATION_TYPE_SEL_BIT]                     = st_q.cfg[idx].arbitration_type_sel;
      end else if (reg_addr_in[8:6] == bus_pkg::PRIO_BASE[8:6]) begin
        for (int m = 0; m < bus_pkg::MASTERS; m++) begin
          st_d.rdata[4 * m +: bus_pkg::PRIO_W] = st_q.prio[idx][m];
        end
      end else if (reg_addr_in[8:6] == bus_pkg::STAT_BASE[8:6]) begin
        st_d.rdata[bus_pkg::MID_W-1:0] = st_q.owner[idx];
        st_d.rdata[bus_pkg::VLD_BIT]   = st_q.vld[idx];
      end
    end
    if (reg_read_in && reg_addr_in == bus_pkg::REMAP_OFF) begin
      st_d.rdata[bus_pkg::MASTERS-1:0] = st_q.remap;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q         <= '0;
      st_q.cfg     <= {bus_pkg::SLAVES{bus_pkg::CFG_RST}};
      st_q.rr_last <= {bus_pkg::SLAVES{bus_pkg::RR_START}};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
endmodule

// ### verification/slave_model.sv
// Memory-like slave model, answering at once or after one wait state
`timescale 1ns/1ps
module slave_model #(
  parameter int WAIT = 0
) (
  input  wire logic           clock_in,
  input  wire logic           rst_in,
  input  wire bus_pkg::sreq_t req_in,
  output bus_pkg::srsp_t      rsp_out
);
  logic        wait_q;
  logic [31:0] junk_q;
  // ==========================================================
  // Wait state; filler is negated each cycle, so from its zero reset value it never changes
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 1'b0;
      junk_q <= 32'h0;
    end else begin
      wait_q <= req_in.sel && !wait_q && (WAIT != 0);
      junk_q <= ~junk_q + 32'h1;
    end
  end
  always_comb begin
    rsp_out.ready = (WAIT == 0) || wait_q || !req_in.sel;
    rsp_out.rdata = req_in.sel ? ~req_in.addr : junk_q;
  end
endmodule

// ### verification/bus_matrix_properties.sv
// Port-level checks of the bus matrix grant and decode behaviour
`timescale 1ns/1ps
module bus_matrix_checker (
  input wire logic                                  clock_in,
  input wire logic                                  rst_in,
  input wire bus_pkg::mreq_t [bus_pkg::MASTERS-1:0] master_req_in,
  input wire bus_pkg::mrsp_t [bus_pkg::MASTERS-1:0] master_rsp_out,
  input wire bus_pkg::sreq_t [bus_pkg::SLAVES-1:0]  slave_req_out,
  input wire bus_pkg::srsp_t [bus_pkg::SLAVES-1:0]  slave_rsp_in,
  input wire logic [bus_pkg::ADDR_W-1:0]            reg_addr_in,
  input wire logic [31:0]                           reg_wdata_in,
  input wire logic                                  reg_write_in,
  input wire logic                                  reg_read_in,
  input wire logic [31:0]                           reg_rdata_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Master one asking for slave two that it does not hold
  sequence s_foreign;
    master_req_in[1].trans != bus_pkg::TRANS_IDLE && master_req_in[1].addr[31:28] == 4'h2
      && slave_req_out[2].owner != 3'h1;
  endsequence
  AST_FOREIGN_WAIT: assert property (s_foreign |-> !master_rsp_out[1].ready)
    else $error("non-owner passed without a grant cycle");
  AST_RD_ONE_CYCLE: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");
  // ==========================================================
  // Per slave
  for (genvar s = 0; s < bus_pkg::SLAVES; s++) begin : g_s
    AST_SEL_TARGET: assert property (slave_req_out[s].sel |->
      master_req_in[slave_req_out[s].owner].addr[31:28] == 4'(s)
      || (s == 1 && master_req_in[slave_req_out[s].owner].addr[31:28] == 4'h0))
      else $error("slave selected for a foreign address");
    AST_GRANT_HOLD: assert property (slave_req_out[s].sel && !slave_rsp_in[s].ready
      |=> slave_req_out[s].sel && $stable(slave_req_out[s].owner))
      else $error("grant moved mid-beat");
    AST_OWNER_PASS: assert property (slave_req_out[s].sel && slave_rsp_in[s].ready
      |-> master_rsp_out[slave_req_out[s].owner].ready)
      else $error("owner delayed");
  end
  // ==========================================================
  // Per master
  for (genvar m = 0; m < bus_pkg::MASTERS; m++) begin : g_m
    AST_IDLE_READY: assert property (master_req_in[m].trans == bus_pkg::TRANS_IDLE
      |-> master_rsp_out[m].ready)
      else $error("idle master stalled");
    AST_UNMAPPED: assert property (master_req_in[m].trans != bus_pkg::TRANS_IDLE
      && master_req_in[m].addr[31:28] >= 4'ha |-> master_rsp_out[m].ready)
      else $error("unmapped access stalled");
    AST_RDATA_ROUTE: assert property (master_rsp_out[m].ready
      && master_req_in[m].trans != bus_pkg::TRANS_IDLE && master_req_in[m].addr[31:28] inside {[1:9]}
      |-> master_rsp_out[m].rdata == slave_rsp_in[master_req_in[m].addr[31:28]].rdata)
      else $error("read data from wrong slave");
  end
endmodule
bind bus_matrix bus_matrix_checker u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .master_req_in(master_req_in), .master_rsp_out(master_rsp_out),
  .slave_req_out(slave_req_out), .slave_rsp_in(slave_rsp_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out));

// ### verification/multilayer_bus_matrix_grant_tb.sv
// Self-checking bench of the bus matrix with ten slave models
`timescale 1ns/1ps
module multilayer_bus_matrix_grant_tb;
  logic                                  clock_in;
  logic                                  rst_in;
  bus_pkg::mreq_t [bus_pkg::MASTERS-1:0] mreq;
  bus_pkg::mrsp_t [bus_pkg::MASTERS-1:0] mrsp;
  bus_pkg::sreq_t [bus_pkg::SLAVES-1:0]  sreq;
  bus_pkg::srsp_t [bus_pkg::SLAVES-1:0]  srsp;
  logic [bus_pkg::ADDR_W-1:0]            reg_addr;
  logic [31:0]                           reg_wdata;
  logic                                  reg_write;
  logic                                  reg_read;
  logic [31:0]                           reg_rdata;
  int                                    err_total = 0;
  int                                    checks = 0;
  int                                    cycles = 0;

  bus_matrix u_dut (.clock_in(clock_in), .rst_in(rst_in), .master_req_in(mreq),
    .master_rsp_out(mrsp), .slave_req_out(sreq), .slave_rsp_in(srsp), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
    .reg_rdata_out(reg_rdata));
  // Slave nine is slow so bursts span several cycles
  for (genvar s = 0; s < bus_pkg::SLAVES; s++) begin : g_slv
    slave_model #(.WAIT((s == 9) ? 1 : 0)) u_slv (.clock_in(clock_in), .rst_in(rst_in),
      .req_in(sreq[s]), .rsp_out(srsp[s]));
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [bus_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_in);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [bus_pkg::ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock_in);
    reg_read <= 1'b0;
    @(negedge clock_in);
    d = reg_rdata;
  endtask
  // Request held until ready; caller releases it at the completing edge
  task automatic beat(input int m, input logic [31:0] a, input logic lst, output int lat);
    @(posedge clock_in);
    mreq[m] <= '{trans: 2'h2, addr: a, write: 1'b0, last: lst, wdata: a};
    lat = 0;
    do begin
      @(negedge clock_in);
      lat++;
    end while (mrsp[m].ready !== 1'b1 && lat < 40);
    if (a[31:28] < 4'ha) check(mrsp[m].rdata, ~a);
  endtask
  task automatic idle(input logic [4:0] mask);
    @(posedge clock_in);
    for (int m = 0; m < 5; m++) if (mask[m]) mreq[m].trans <= bus_pkg::TRANS_IDLE;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] d;
    for (int s = 0; s < bus_pkg::SLAVES; s++) begin
      reg_rd(bus_pkg::CFG_BASE + 9'(4 * s), d);
      check(d, 32'h0001_0010);
    end
    reg_wr(9'h0c8, 32'hffff_ffff);
    reg_rd(9'h0c8, d);
    check(d, 32'h0);
    reg_rd(9'h1fc, d);
    check(d, 32'h0);
  endtask
  task automatic t_last();
    int lat;
    beat(1, 32'h3000_0010, 1'b1, lat);
    check(lat, 2);
    idle(5'h02);
    @(negedge clock_in);
    check({sreq[3].sel, sreq[3].owner}, 32'h1);
    beat(1, 32'h3000_0020, 1'b1, lat);
    check(lat, 1);
    idle(5'h02);
    beat(1, 32'h2000_0000, 1'b1, lat);
    check(lat, 2);
    idle(5'h02);
    beat(4, 32'ha000_0000, 1'b1, lat);
    check(lat, 1);
    idle(5'h10);
  endtask
  // Kinds none, reserved and fixed; fixed owner 3 only counts for kind 2
  task automatic t_kinds();
    int lat;
    logic [31:0] d;
    logic [31:0] cfg;
    for (int i = 0; i < 3; i++) begin
      cfg = 32'h000c_0010 | (32'((3 * i) % 4) << 16);
      reg_wr(bus_pkg::CFG_BASE + 9'(16 + 4 * i), cfg);
      beat(0, {4'(4 + i), 28'h40}, 1'b1, lat);
      check(lat, 2);
      idle(5'h01);
      // Completing edge regrants the requester; default owner applies one cycle on
      repeat (2) @(negedge clock_in);
      check({sreq[4+i].sel, sreq[4+i].trans, sreq[4+i].owner}, (i == 2) ? 32'h3 : 32'h0);
      reg_rd(bus_pkg::STAT_BASE + 9'(16 + 4 * i), d);
      check(d, (i == 2) ? 32'h13 : 32'h0);
      reg_rd(bus_pkg::CFG_BASE + 9'(16 + 4 * i), d);
      check(d, cfg);
    end
    beat(3, 32'h6000_0000, 1'b1, lat);
    check(lat, 1);
    idle(5'h08);
  endtask
  // Simultaneous single beats; completion order packed three bits a master
  task automatic t_order(input int s, input logic [4:0] mask, input logic [11:0] exp);
    logic [11:0] seen;
    logic [4:0]  busy;
    logic [4:0]  done;
    seen = '0;
    busy = mask;
    @(posedge clock_in);
    for (int m = 0; m < 5; m++) if (mask[m]) mreq[m] <= '{2'h2, {4'(s), 28'h0}, 1'b0, 1'b1, 32'h0};
    for (int c = 0; c < 30 && busy != 5'h0; c++) begin
      @(negedge clock_in);
      done = busy & {mrsp[4].ready, mrsp[3].ready, mrsp[2].ready, mrsp[1].ready, mrsp[0].ready};
      for (int m = 0; m < 5; m++) if (done[m] === 1'b1) seen = {seen[8:0], 3'(m)};
      busy = busy & ~done;
      idle(done);
    end
    check(seen, exp);
  endtask
  task automatic t_burst();
    int lat;
    int lat1;
    beat(0, 32'h9000_0000, 1'b0, lat);
    fork
      begin
        beat(0, 32'h9000_0004, 1'b0, lat);
        beat(0, 32'h9000_0008, 1'b0, lat);
        beat(0, 32'h9000_000c, 1'b1, lat);
        idle(5'h01);
      end
      beat(1, 32'h9000_0100, 1'b1, lat1);
    join
    idle(5'h02);
    check(lat1, 8);
  endtask
  task automatic t_remap();
    int lat;
    int lat1;
    logic [31:0] d;
    reg_wr(bus_pkg::REMAP_OFF, 32'h4);
    fork
      beat(2, 32'h0000_0008, 1'b1, lat);
      beat(0, 32'h0000_0008, 1'b1, lat1);
    join
    idle(5'h05);
    @(negedge clock_in);
    check(lat, 2);
    check(lat1, 2);
    check(sreq[1].owner, 32'h2);
    reg_rd(bus_pkg::STAT_BASE, d);
    check(d, 32'h10);
    reg_rd(bus_pkg::STAT_BASE + 9'h4, d);
    check(d, 32'h12);
  endtask
  // ==========================================================
  // Clock, timeout and main sequence
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    mreq = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    @(negedge clock_in);
    t_regs();
    t_last();
    t_kinds();
    reg_wr(9'h0a0, 32'h89);
    reg_wr(bus_pkg::CFG_BASE + 9'h20, 32'h0101_0010);
    t_order(8, 5'b01011, 12'h019);
    t_order(7, 5'b00111, 12'h00a);
    t_order(7, 5'b01101, 12'h098);
    t_burst();
    t_remap();
    stop_test();
  end
endmodule
